// ### verilog/spp_port_top.sv
// Seven shared-pin parallel ports with pin ownership and pin controls
`timescale 1ns/1ns
`include "spp_consts.svh"

// Overview of operation
// [RULE1] 54 pins, seven ports, free pins plain I/O
// [RULE2] Reset leaves every pin under port control
// [RULE3] Reset clears all direction bits to input
// [RULE4] Reset: slew on, low drive, pull-up off
// [RULE5] Analog input disables the pin's digital function
// [RULE6] Enabled peripheral overrides the direction bit
// [RULE7] Peripheral output data replaces port value
// [RULE8] Analog converter wins over digital peripherals
// [RULE9] Value/direction page zero, pin controls high page
// [RULE10] Port C: serial two, two-wire, clock out
// [RULE11] Port D: analog, keypad, timer clock inputs
// [RULE12] Port E serial/SPI/timer, port F timers
// [RULE13] Read gives pin if input, latch if output
// [RULE14] Read gives zero on analog-claimed bits
// [RULE15] Pull-up off for outputs and analog pins
// [RULE16] Fixed priority mux: analog, peripheral, port
module spp_port_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Pin levels from the pads
  input wire logic [53:0] pin_in_i,
  // Register write port
  input wire logic wr_en_i,
  input wire logic wr_high_page_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // Register read port
  input wire logic rd_high_page_i,
  input wire logic [4:0] rd_addr_i,
  output logic [7:0] rd_data_o,
  // Peripheral claims, one bit per pin
  input wire logic [53:0] adc_en_i,
  input wire logic [53:0] per_en_i,
  input wire logic [53:0] per_oe_i,
  input wire logic [53:0] per_out_i,
  // Pad controls
  output logic [53:0] pin_out_o,
  output logic [53:0] pin_oe_o,
  output logic [53:0] pull_en_o,
  output logic [53:0] slew_lim_o,
  output logic [53:0] high_drive_o
);

  spp_pkg::spp_state_t q; // Registered state
  spp_pkg::spp_state_t d; // Next state
  logic rst_n; // Reset with synchronous release
  logic [53:0] lvl; // Synchronised pin levels
  logic [53:0] adc_claim; // Analog claims on capable pins
  logic [53:0] dig_claim; // Digital claims on capable pins
  logic [53:0] own_oe; // Chosen output enable
  logic [53:0] own_out; // Chosen output level
  logic [53:0] own_pull; // Effective pull-up
  logic [53:0] own_rd; // Read value per pin

  // First pin of a port
  function automatic int port_base(input int p);
    case (p)
      0: port_base = `SPP_BASE_A;
      1: port_base = `SPP_BASE_B;
      2: port_base = `SPP_BASE_C;
      3: port_base = `SPP_BASE_D;
      4: port_base = `SPP_BASE_E;
      5: port_base = `SPP_BASE_F;
      default: port_base = `SPP_BASE_G;
    endcase
  endfunction

  // Pin count of a port: C and G are narrow
  function automatic int port_width(input int p);
    if (p == 2 || p == 6)
      port_width = `SPP_NARROW_PORT;
    else
      port_width = `SPP_WIDE_PORT;
  endfunction

  // Register kind at a page and offset for one port
  function automatic spp_pkg::spp_kind_t decode(input logic hp,
    input logic [4:0] a, input int p);
    decode = spp_pkg::SPP_KIND_NONE;
    if (!hp)
    begin
      // Page zero holds value and direction
      if (a == 5'(p * `SPP_PZ_STRIDE + `SPP_PZ_VALUE))  // RULE9
        decode = spp_pkg::SPP_KIND_VALUE;
      else if (a == 5'(p * `SPP_PZ_STRIDE + `SPP_PZ_DIR))
        decode = spp_pkg::SPP_KIND_DIR;
    end
    else
    begin
      // High page holds the pin controls
      if (a == 5'(p * `SPP_HP_STRIDE + `SPP_HP_PULL))  // RULE9
        decode = spp_pkg::SPP_KIND_PULL;
      else if (a == 5'(p * `SPP_HP_STRIDE + `SPP_HP_SLEW))
        decode = spp_pkg::SPP_KIND_SLEW;
      else if (a == 5'(p * `SPP_HP_STRIDE + `SPP_HP_DRIVE))
        decode = spp_pkg::SPP_KIND_DRIVE;
    end
  endfunction

  // Reset release through two flops
  spp_sync2 #(
    .WIDTH(1),
    .RST_VAL(1'b0)
  ) u_rst_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .d_i(1'b1),
    .q_o(rst_n)
  );

  // Pad levels through two flops
  spp_sync2 #(
    .WIDTH(54),
    .RST_VAL(54'h00_0000_0000_0000)
  ) u_pin_sync (
    .clk_i(clk_i),
    .arst_n_i(rst_n),
    .d_i(pin_in_i),
    .q_o(lvl)
  );

  // Claims only count on pins wired to that peripheral
  assign adc_claim = adc_en_i & `SPP_ADC_MASK;  // RULE11
  assign dig_claim = per_en_i & `SPP_DIG_MASK;  // RULE10 RULE11 RULE12

  // One ownership mux per pin
  for (genvar i = 0; i < `SPP_NPINS; i++)
  begin : g_pin
    spp_pin_own u_own (
      .val_i(q.val[i]),
      .dir_i(q.dir[i]),
      .pe_i(q.pe[i]),
      .adc_i(adc_claim[i]),
      .per_en_i(dig_claim[i]),
      .per_oe_i(per_oe_i[i]),
      .per_out_i(per_out_i[i]),
      .lvl_i(lvl[i]),
      .oe_o(own_oe[i]),
      .out_o(own_out[i]),
      .pull_o(own_pull[i]),
      .rd_o(own_rd[i])
    );
  end

  // Next state: register writes, reads and pad controls
  always_comb
  begin
    int base;
    int w;
    spp_pkg::spp_kind_t wk;
    spp_pkg::spp_kind_t rk;
    base = 0;
    w = 0;
    wk = spp_pkg::SPP_KIND_NONE;
    rk = spp_pkg::SPP_KIND_NONE;
    d = q;
    d.rdat = 8'h00;
    for (int p = 0; p < `SPP_NPORTS; p++)
    begin
      base = port_base(p);
      w = port_width(p);
      wk = wr_en_i ? decode(wr_high_page_i, wr_addr_i, p)
                   : spp_pkg::SPP_KIND_NONE;
      rk = decode(rd_high_page_i, rd_addr_i, p);
      for (int b = 0; b < 8; b++)
      begin
        // Narrow ports have no pin behind bit 7
        if (b < w)
        begin
          // Write the addressed register bit
          case (wk)
            spp_pkg::SPP_KIND_VALUE: d.val[base + b] = wr_data_i[b];
            spp_pkg::SPP_KIND_DIR: d.dir[base + b] = wr_data_i[b];
            spp_pkg::SPP_KIND_PULL: d.pe[base + b] = wr_data_i[b];
            spp_pkg::SPP_KIND_SLEW: d.se[base + b] = wr_data_i[b];
            spp_pkg::SPP_KIND_DRIVE: d.ds[base + b] = wr_data_i[b];
            default: ;
          endcase
          // Read the addressed register bit
          case (rk)
            spp_pkg::SPP_KIND_VALUE: d.rdat[b] = own_rd[base + b];  // RULE13
            spp_pkg::SPP_KIND_DIR: d.rdat[b] = q.dir[base + b];
            spp_pkg::SPP_KIND_PULL: d.rdat[b] = q.pe[base + b];
            spp_pkg::SPP_KIND_SLEW: d.rdat[b] = q.se[base + b];
            spp_pkg::SPP_KIND_DRIVE: d.rdat[b] = q.ds[base + b];
            default: ;
          endcase
        end
      end
    end
    // Pad controls follow the ownership mux
    d.pout = own_out;  // RULE7
    d.poe = own_oe;  // RULE6
    d.pull = own_pull;  // RULE15
  end

  // State register; reset puts every pin under port control
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q.val <= `SPP_RST_VALUE;
      q.dir <= `SPP_RST_DIR;  // RULE3
      q.pe <= `SPP_RST_PULL;  // RULE4
      q.se <= `SPP_RST_SLEW;  // RULE4
      q.ds <= `SPP_RST_DRIVE;  // RULE4
      q.pout <= 54'h00_0000_0000_0000;  // RULE2
      q.poe <= 54'h00_0000_0000_0000;  // RULE2
      q.pull <= 54'h00_0000_0000_0000;
      q.rdat <= 8'h00;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign rd_data_o = q.rdat;
  assign pin_out_o = q.pout;
  assign pin_oe_o = q.poe;
  assign pull_en_o = q.pull;
  assign slew_lim_o = q.se;
  assign high_drive_o = q.ds;

  // Checks on the registered behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // Free pins follow the port registers

  AST_FREE_PIN_PORT: assert property ( // RULE1
    ((q.poe ^ $past(q.dir)) & $past(~(adc_claim | dig_claim))) == '0)
    else $error("free pin direction not from port");
  AST_FREE_PIN_DATA: assert property ( // RULE1
    ((q.pout ^ $past(q.val)) & $past(~(adc_claim | dig_claim))) == '0)
    else $error("free pin data not from port");

  // Reset defaults
  AST_RESET_PORT_CTRL: assert property ( // RULE2
    $rose(rst_n) |-> (q.pout == '0 && q.pull == '0 && q.rdat == 8'h00))
    else $error("pins not under port control after reset");
  AST_RESET_INPUTS: assert property ( // RULE3
    $rose(rst_n) |-> (q.dir == '0 && q.poe == '0))
    else $error("pins not inputs after reset");
  AST_RESET_PIN_CTRL: assert property ( // RULE4
    $rose(rst_n) |-> (q.se == `SPP_RST_SLEW && q.ds == '0 && q.pe == '0))
    else $error("pin controls wrong after reset");

  // Ownership and priority
  AST_ADC_NO_DRIVE: assert property ( // RULE5
    ((q.poe | q.pout) & $past(adc_claim)) == '0)
    else $error("analog pin still driven");
  AST_PERIPH_DIR: assert property ( // RULE6
    ((q.poe ^ $past(per_oe_i)) & $past(dig_claim & ~adc_claim)) == '0)
    else $error("peripheral direction not applied");
  AST_PERIPH_DATA: assert property ( // RULE7
    ((q.pout ^ $past(per_out_i)) & $past(dig_claim & ~adc_claim & per_oe_i))
      == '0)
    else $error("peripheral data not applied");
  AST_ADC_WINS: assert property ( // RULE8
    (adc_en_i[30] && per_en_i[30]) |=> !q.poe[30])
    else $error("analog lost pin to keypad");

  // Register map and reads
  AST_PAGE_SPLIT: assert property ( // RULE9
    (wr_en_i && wr_high_page_i && wr_addr_i == 5'h00) |=>
      (q.val[7:0] == $past(q.val[7:0]) && q.pe[7:0] == $past(wr_data_i)))
    else $error("high page write hit page zero");
  AST_NARROW_BIT7: assert property ( // RULE1
    (wr_en_i && !wr_high_page_i && wr_addr_i == 5'h05) |=>
      (q.dir[23] == $past(q.dir[23]) &&
       q.dir[22:16] == $past(wr_data_i[6:0])))
    else $error("narrow port write leaked into next port");
  AST_DRIVE_WRITE: assert property ( // RULE9
    (wr_en_i && wr_high_page_i && wr_addr_i == 5'h02) |=>
      q.ds[7:0] == $past(wr_data_i))
    else $error("drive write not applied");
  AST_READ_PORT_A: assert property ( // RULE13
    (!rd_high_page_i && rd_addr_i == 5'h00) |=>
      q.rdat == $past((q.dir[7:0] & q.val[7:0]) | (~q.dir[7:0] & lvl[7:0])))
    else $error("port value read wrong");
  AST_READ_ADC_ZERO: assert property ( // RULE14
    (!rd_high_page_i && rd_addr_i == 5'h02) |=>
      (q.rdat & $past(adc_claim[15:8])) == 8'h00)
    else $error("analog bit read nonzero");
  AST_UNMAPPED_READ: assert property ( // RULE9
    (!rd_high_page_i && rd_addr_i == 5'h1f) |=> q.rdat == 8'h00)
    else $error("unmapped read nonzero");
  AST_PULL_OFF: assert property ( // RULE15
    (q.pull & (q.poe | $past(adc_claim))) == '0)
    else $error("pull-up on output or analog pin");

  // Main scenarios worth seeing
  COV_ADC_CLAIM: cover property (|adc_claim ##1 |q.pull);
  COV_PERIPH_DRIVE: cover property ((dig_claim[31] && per_oe_i[31])
    ##1 q.poe[31]);
  COV_ADC_OVER_KEYPAD: cover property ((adc_claim[30] && dig_claim[30])
    ##1 !q.poe[30]);
  COV_PULLED_INPUT: cover property (|(q.pull & lvl));
  COV_PORT_OUTPUT: cover property ((wr_en_i && !wr_high_page_i &&
    wr_addr_i == 5'h01) ##1 |q.poe[7:0]);

endmodule

// ### verilog/spp_consts.svh
// Offsets, pin layout, sharing masks and reset values of the parallel port
`ifndef SPP_CONSTS_SVH
`define SPP_CONSTS_SVH

// Pin and port counts
`define SPP_NPINS 54
`define SPP_NPORTS 7

// First pin index of each port in the flat pin vectors
`define SPP_BASE_A 0
`define SPP_BASE_B 8
`define SPP_BASE_C 16
`define SPP_BASE_D 23
`define SPP_BASE_E 31
`define SPP_BASE_F 39
`define SPP_BASE_G 47

// Pins per port
`define SPP_WIDE_PORT 8
`define SPP_NARROW_PORT 7

// Page-zero layout: value and direction, two offsets per port
`define SPP_PZ_STRIDE 2
`define SPP_PZ_VALUE 0
`define SPP_PZ_DIR 1

// High-page layout: pull-up, slew and drive, four offsets per port
`define SPP_HP_STRIDE 4
`define SPP_HP_PULL 0
`define SPP_HP_SLEW 1
`define SPP_HP_DRIVE 2

// Pins that digital peripherals may claim: ports C, D, E, F, G
`define SPP_DIG_MASK 54'h3f_ffff_ffff_0000
// Pins that the analog converter may claim: ports B and D
`define SPP_ADC_MASK 54'h00_0000_7f80_ff00

// Reset values of the per-pin controls
`define SPP_RST_VALUE 54'h00_0000_0000_0000
`define SPP_RST_DIR 54'h00_0000_0000_0000
`define SPP_RST_PULL 54'h00_0000_0000_0000
`define SPP_RST_SLEW 54'h3f_ffff_ffff_ffff
`define SPP_RST_DRIVE 54'h00_0000_0000_0000

`endif

// ### verilog/spp_pkg.sv
// Types shared by the parallel port design files
package spp_pkg;

  // Register kind selected by a page and offset
  typedef enum logic [2:0] {
    SPP_KIND_NONE,
    SPP_KIND_VALUE,
    SPP_KIND_DIR,
    SPP_KIND_PULL,
    SPP_KIND_SLEW,
    SPP_KIND_DRIVE
  } spp_kind_t;

  // Whole state of the port block
  typedef struct packed {
    logic [53:0] val;   // Port value register bits
    logic [53:0] dir;   // Pin direction bits
    logic [53:0] pe;    // Pull-up enable bits
    logic [53:0] se;    // Slew limit bits
    logic [53:0] ds;    // High drive bits
    logic [53:0] pout;  // Pin output level
    logic [53:0] poe;   // Pin output enable
    logic [53:0] pull;  // Effective pull-up
    logic [7:0] rdat;   // Read data
  } spp_state_t;

endpackage

// ### verilog/spp_sync2.sv
// Two-stage synchroniser with a constant reset value
`timescale 1ns/1ns
module spp_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q; // First stage, read only by second

  // Two flops in series
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// ### verilog/spp_pin_own.sv
// Per-pin ownership mux: analog, then peripheral, then port
`timescale 1ns/1ns
module spp_pin_own (
  // Port side controls
  input wire logic val_i,
  input wire logic dir_i,
  input wire logic pe_i,
  // Claims from peripherals
  input wire logic adc_i,
  input wire logic per_en_i,
  input wire logic per_oe_i,
  input wire logic per_out_i,
  // Synchronised pin level
  input wire logic lvl_i,
  // Results
  output logic oe_o,
  output logic out_o,
  output logic pull_o,
  output logic rd_o
);

  // Fixed priority choice of pin owner
  always_comb
  begin
    if (adc_i)
    begin
      // Analog owns the pin: digital off
      oe_o = 1'b0;  // RULE5 RULE8 RULE16
      out_o = 1'b0;
    end
    else if (per_en_i)
    begin
      // Peripheral sets direction and data
      oe_o = per_oe_i;  // RULE6 RULE16
      out_o = per_out_i;  // RULE7
    end
    else
    begin
      // Plain port control
      oe_o = dir_i;  // RULE1 RULE16
      out_o = val_i;
    end
    // Pull-up only on a non-analog input
    pull_o = pe_i & ~oe_o & ~adc_i;  // RULE15
    // Read: zero on analog, else latch or pin
    if (adc_i)
      rd_o = 1'b0;  // RULE14
    else if (dir_i)
      rd_o = val_i;  // RULE13
    else
      rd_o = lvl_i;  // RULE13
  end

endmodule

// ### tb/spp_pad_model.sv
// Board and pad model: resolves each pin level seen by the port
`timescale 1ns/1ns
module spp_pad_model (
  // Clock
  input wire logic clk_i,
  // Pad controls from the port block
  input wire logic [53:0] pin_out_i,
  input wire logic [53:0] pin_oe_i,
  input wire logic [53:0] pull_en_i,
  // Board drivers
  input wire logic [53:0] ext_en_i,
  input wire logic [53:0] ext_val_i,
  // Resolved pad level
  output logic [53:0] pad_o
);
  // Undriven, unpulled pins wander every cycle
  logic [53:0] float_q = '0;

  // Toggle the floating pattern
  always_ff @(posedge clk_i)
  begin
    float_q <= ~float_q;
  end

  // Port drive first, then board, then pull-up, else floating
  assign pad_o = (pin_oe_i & pin_out_i)
    | (~pin_oe_i & ext_en_i & ext_val_i)
    | (~pin_oe_i & ~ext_en_i & pull_en_i)
    | (~pin_oe_i & ~ext_en_i & ~pull_en_i & float_q);
endmodule

// ### tb/tb.sv
// Self-checking bench for the shared-pin parallel port
`timescale 1ns/1ns
`include "spp_consts.svh"
module tb;
  // Design inputs
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic wr_high_page_i = 1'b0;
  logic rd_high_page_i = 1'b0;
  logic [4:0] wr_addr_i = 5'h00;
  logic [4:0] rd_addr_i = 5'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic [53:0] adc = '0, pen = '0, poe = '0, pout = '0;
  // Board drive
  logic [53:0] ext_en = '1, ext_val = '0;
  // Design outputs and resolved pads
  logic [7:0] rd_data_o;
  logic [53:0] pad, pin_out_o, pin_oe_o, pull_en_o, slew_lim_o, high_drive_o;
  // Mirror: value, dir, pull, slew, drive
  logic [53:0] m [5];
  int fail_count = 0;
  int checked = 0;
  int seed = 32'ha5c9;
  int base [7] = '{0, 8, 16, 23, 31, 39, 47};
  int wid [7] = '{8, 8, 7, 8, 8, 8, 7};

  // 250 MHz clock
  always #2 clk_i = ~clk_i;

  spp_port_top u_dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .pin_in_i(pad),
    .wr_en_i(wr_en_i), .wr_high_page_i(wr_high_page_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
    .rd_high_page_i(rd_high_page_i), .rd_addr_i(rd_addr_i),
    .rd_data_o(rd_data_o), .adc_en_i(adc), .per_en_i(pen),
    .per_oe_i(poe), .per_out_i(pout), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .pull_en_o(pull_en_o),
    .slew_lim_o(slew_lim_o), .high_drive_o(high_drive_o)
  );

  spp_pad_model u_pads (
    .clk_i(clk_i), .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o),
    .pull_en_i(pull_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pad_o(pad)
  );

  // Random 54-bit word
  function automatic logic [53:0] rnd54();
    return 54'({$random(seed), $random(seed)});
  endfunction
  // Honoured analog claims
  function automatic logic [53:0] own_adc();
    return adc & `SPP_ADC_MASK;
  endfunction
  // Honoured digital claims, analog wins
  function automatic logic [53:0] own_per();
    return pen & `SPP_DIG_MASK & ~own_adc();
  endfunction
  function automatic logic [53:0] exp_oe();
    return (own_per() & poe) | (~own_per() & ~own_adc() & m[1]);
  endfunction
  function automatic logic [53:0] exp_out();
    return (own_per() & pout) | (~own_per() & ~own_adc() & m[0]);
  endfunction
  function automatic logic [53:0] exp_pull();
    return m[2] & ~exp_oe() & ~own_adc();
  endfunction
  // Pad level wherever it is defined
  function automatic logic [53:0] exp_pad();
    return (exp_oe() & exp_out()) | (~exp_oe() & ext_en & ext_val)
      | (~exp_oe() & ~ext_en & exp_pull());
  endfunction
  // Pins whose value read is predictable
  function automatic logic [53:0] exp_known();
    return exp_oe() | ext_en | exp_pull() | m[1] | own_adc();
  endfunction
  function automatic logic [53:0] exp_rd();
    return ~own_adc() & ((m[1] & m[0]) | (~m[1] & exp_pad()));
  endfunction
  // Gather one port's bits
  function automatic logic [7:0] port_bits(logic [53:0] v, int p);
    logic [7:0] r;
    r = 8'h00;
    for (int b = 0; b < wid[p]; b++)
      r[b] = v[base[p] + b];
    return r;
  endfunction

  // Count and report one comparison
  task automatic chk(string name, logic [63:0] e, logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  // One write pulse, then update the mirror
  task automatic wr(logic hp, logic [4:0] a, logic [7:0] d);
    int p;
    int k;
    @(posedge clk_i) #1;
    wr_en_i = 1'b1;
    wr_high_page_i = hp;
    wr_addr_i = a;
    wr_data_i = d;
    @(posedge clk_i) #1;
    wr_en_i = 1'b0;
    p = hp ? a / 4 : a / 2;
    k = hp ? 2 + a % 4 : a % 2;
    // Unmapped offsets and narrow bit 7 change nothing
    if (p < 7 && k < 5)
      for (int b = 0; b < wid[p]; b++)
        m[k][base[p] + b] = d[b];
  endtask

  // Select, then take the registered answer
  task automatic rd(logic hp, logic [4:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    rd_high_page_i = hp;
    rd_addr_i = a;
    @(posedge clk_i) #1;
    d = rd_data_o;
  endtask

  // Read all six offsets of a port plus an unmapped one
  task automatic chk_regs(int p);
    logic [7:0] d, e, msk;
    for (int o = 0; o < 6; o++)
    begin
      rd(o > 1, o > 1 ? 5'(4 * p + o - 2) : 5'(2 * p + o), d);
      e = o == 5 ? 8'h00 : port_bits(o == 0 ? exp_rd() : m[o], p);
      msk = o == 0 ? port_bits(exp_known(), p) : 8'hff;
      chk("register read", 64'(e & msk), 64'(d & msk));
    end
    rd(1'b0, 5'h1f, d);
    chk("unmapped read", 64'h0, 64'(d));
  endtask

  // Pad controls against expectation
  task automatic chk_pads();
    logic [53:0] oe;
    oe = exp_oe();
    chk("pin_oe_o", 64'(oe), 64'(pin_oe_o));
    chk("pin_out_o", 64'(exp_out() & oe), 64'(pin_out_o & oe));
    chk("pull_en_o", 64'(exp_pull()), 64'(pull_en_o));
    chk("slew_lim_o", 64'(m[3]), 64'(slew_lim_o));
    chk("high_drive_o", 64'(m[4]), 64'(high_drive_o));
  endtask

  // Let pads, synchronisers and reads settle
  task automatic settle();
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  // Reset for 3 cycles and reload the mirror
  task automatic do_reset();
    arst_n_i = 1'b0;
    for (int k = 0; k < 5; k++)
      m[k] = k == 3 ? {54{1'b1}} : 54'h0;
    repeat (3) @(posedge clk_i);
    #1;
    arst_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // Counts, verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    do_reset();
    chk_pads();
    for (int p = 0; p < 7; p++)
      chk_regs(p);
    $display("test reset done");
    // Every pin an output with a pattern
    ext_val = rnd54();
    for (int p = 0; p < 7; p++)
    begin
      wr(1'b0, 5'(2 * p), 8'h5a ^ 8'(p));
      wr(1'b0, 5'(2 * p + 1), 8'hff);
    end
    settle();
    chk_pads();
    chk_regs(3);
    $display("test outputs done");
    // Analog and digital claims on every pin
    adc = '1;
    pen = '1;
    poe = '1;
    pout = '1;
    settle();
    chk_pads();
    chk("port_d_bit_seven oe", 64'h0, 64'(pin_oe_o[30]));
    chk_regs(1);
    chk_regs(3);
    $display("test claims done");
    // Clock-out pin owned by a peripheral, port bit an input
    adc = '0;
    pen = 54'h1 << 18;
    poe = pen;
    wr(1'b0, 5'h05, 8'h00);
    settle();
    chk("port_c_bit_two", 64'h1, 64'(pin_oe_o[18] & pin_out_o[18]));
    chk_pads();
    $display("test clock pin done");
    // Floating inputs with pull-ups
    for (int p = 0; p < 7; p++)
    begin
      wr(1'b0, 5'(2 * p + 1), 8'h0f);
      wr(1'b1, 5'(4 * p), 8'hff);
    end
    ext_en = '0;
    settle();
    chk_pads();
    for (int p = 0; p < 7; p++)
      chk_regs(p);
    $display("test pull-ups done");
    // Random traffic
    repeat (40)
    begin
      adc = rnd54();
      pen = rnd54();
      poe = rnd54();
      pout = rnd54();
      ext_en = rnd54();
      ext_val = rnd54();
      wr(1'($random(seed)), 5'($random(seed)), 8'($random(seed)));
      settle();
      chk_pads();
      chk_regs({$random(seed)} % 7);
    end
    $display("test random done");
    // Second reset in mid-run
    adc = '0;
    pen = '0;
    do_reset();
    chk_pads();
    chk_regs(4);
    $display("test second reset done");
    complete_run();
  end
endmodule
